// >>> rtl/sarc_top.sv
`timescale 1ns/1ps
module sarc_top #(
  parameter int BUF_DEPTH = 16
)(
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // power state and trigger events
  input  wire logic        IDLE_I,
  input  wire logic        EXT_PIN_I,
  input  wire logic        T3_EVT_I,
  input  wire logic        T5_EVT_I,
  input  wire logic        CHARGE_TIME_UNIT_EVT_I,
  // analog front end
  input  wire logic [9:0]  ADC_DATA_I,
  output logic             SAMPLE_O,
  output logic             CONVERT_O,
  output logic      [4:0]  CH_POS_O,
  output logic             CH_NEG_O,
  output logic             REF_POS_EXT_O,
  output logic             REF_NEG_EXT_O,
  output logic      [17:0] ANALOG_EN_O,
  output logic             RC_CLK_SEL_O,
  // conversion event
  output logic             CONV_IRQ_O
);
  if (BUF_DEPTH != 16) begin : g_depth_chk
    $error("sarc_top: BUF_DEPTH must be 16");
  end

  sarc_buf_if #(.W(16), .AW(4)) bw ();
  sarc_result_mem #(.W(16), .AW(4), .DEPTH(BUF_DEPTH)) u_mem (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .bus   (bw)
  );

  // ---------------- register file ----------------
  logic [15:0] c1, c2, c3, chsel, pcfgl, scan_channel_select;
  logic [1:0]  pcfgh;
  logic [15:0] next_c1, next_c2, next_c3, next_chsel, next_pcfgl;
  logic [15:0] next_scan_channel_select;
  logic [1:0]  next_pcfgh;
  logic        wr, hit, buf_hit;
  logic [15:0] rdat;
  // sequencer state
  sarc_pkg::sarc_state_type st, next_st;
  logic       sample_enable, done, buffer_fill_status, alt_b, irq;
  logic       next_sample_enable, next_done, next_buffer_fill_status, next_alt_b, next_irq;
  logic [7:0] div_cnt, next_div_cnt;
  logic [4:0] sample_enable_cnt, next_sample_enable_cnt;
  logic [3:0] conv_cnt, seq_cnt, wptr, scan_ptr;
  logic [3:0] next_conv_cnt, next_seq_cnt, next_wptr, next_scan_ptr;
  logic       wen, next_wen;
  logic [3:0] waddr, next_waddr;
  logic [15:0] wdata, next_wdata;
  logic [2:0] ext_s;
  logic       ext_lvl, next_ext_lvl;
  logic       ext_edge, halted, tad_tick, trig_evt, conv_end, seq_last;
  logic       sw_sample_enable_wr;
  logic [2:0] trig;
  logic [4:0] pos_sel;

  assign buf_hit = PADDR_I[7:6] == sarc_pkg::BUF_WIN;
  assign wr = PSEL_I & PENABLE_I & PWRITE_I;
  assign bw.rd_addr = PADDR_I[5:2];
  // buffer read data registers off the setup-phase address: no wait state
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;
  assign PRDATA_O = {16'h0000, rdat};

  always_comb
  begin
    hit = 1'b1;
    rdat = 16'h0000;
    if (PADDR_I == sarc_pkg::OFF_CTRL1)
      rdat = c1 | {14'h0000, sample_enable, done};
    else if (PADDR_I == sarc_pkg::OFF_CTRL2)
      rdat = c2 | {8'h00, buffer_fill_status, 7'h00};
    else if (PADDR_I == sarc_pkg::OFF_CTRL3)
      rdat = c3;
    else if (PADDR_I == sarc_pkg::OFF_CHSEL)
      rdat = chsel;
    else if (PADDR_I == sarc_pkg::OFF_PCFGL)
      rdat = pcfgl;
    else if (PADDR_I == sarc_pkg::OFF_PCFGH)
      rdat = {14'h0000, pcfgh};
    else if (PADDR_I == sarc_pkg::OFF_SCAN)
      rdat = scan_channel_select;
    else if (buf_hit && PADDR_I[1:0] == 2'h0)
      rdat = bw.rd_data;
    else
      hit = 1'b0;
  end

  always_comb
  begin
    next_c1 = c1;
    next_c2 = c2;
    next_c3 = c3;
    next_chsel = chsel;
    next_pcfgl = pcfgl;
    next_pcfgh = pcfgh;
    next_scan_channel_select = scan_channel_select;
    if (wr && PADDR_I == sarc_pkg::OFF_CTRL1)
      next_c1 = PWDATA_I[15:0] & sarc_pkg::C1_WMASK;
    else if (wr && PADDR_I == sarc_pkg::OFF_CTRL2)
      next_c2 = PWDATA_I[15:0] & sarc_pkg::C2_WMASK;
    else if (wr && PADDR_I == sarc_pkg::OFF_CTRL3)
      next_c3 = PWDATA_I[15:0] & sarc_pkg::C3_WMASK;
    else if (wr && PADDR_I == sarc_pkg::OFF_CHSEL)
      next_chsel = PWDATA_I[15:0] & sarc_pkg::CH_WMASK;
    else if (wr && PADDR_I == sarc_pkg::OFF_PCFGL)
      next_pcfgl = PWDATA_I[15:0];
    else if (wr && PADDR_I == sarc_pkg::OFF_PCFGH)
      next_pcfgh = PWDATA_I[1:0] & sarc_pkg::PH_WMASK[1:0];
    else if (wr && PADDR_I == sarc_pkg::OFF_SCAN)
      next_scan_channel_select = PWDATA_I[15:0];
  end

  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      c1 <= sarc_pkg::RST_REG;
      c2 <= sarc_pkg::RST_REG;
      c3 <= sarc_pkg::RST_REG;
      chsel <= sarc_pkg::RST_REG;
      pcfgl <= sarc_pkg::RST_REG;
      pcfgh <= 2'h0;
      scan_channel_select <= sarc_pkg::RST_REG;
    end
    else
    begin
      c1 <= next_c1;
      c2 <= next_c2;
      c3 <= next_c3;
      chsel <= next_chsel;
      pcfgl <= next_pcfgl;
      pcfgh <= next_pcfgh;
      scan_channel_select <= next_scan_channel_select;
    end
  end

  // ---------------- helpers ----------------
  function automatic logic [3:0] scan_next(input logic [3:0]  cur,
                                           input logic [15:0] m);
    logic [3:0] r;
    logic [3:0] idx;
    logic       found;
    r = cur;
    found = 1'b0;
    for (int k = 1; k <= 16; k++)
    begin
      idx = cur + 4'(k);
      if (!found && m[idx])
      begin
        r = idx;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] fmt(input logic [9:0] d,
                                      input logic [1:0] f);
    logic [15:0] r;
    r = {6'h00, d};
    case (f)
      sarc_pkg::FMT_SINT:  r = {{7{~d[9]}}, d[8:0]};
      sarc_pkg::FMT_FRAC:  r = {d, 6'h00};
      sarc_pkg::FMT_SFRAC: r = {~d[9], d[8:0], 6'h00};
      default:             r = {6'h00, d};
    endcase
    return r;
  endfunction

  // ---------------- sequencer ----------------
  assign trig = c1[sarc_pkg::C1_TRIG +: 3];
  assign halted = IDLE_I & c1[sarc_pkg::C1_SIDL];
  assign tad_tick = div_cnt == c3[sarc_pkg::C3_DIV +: 8];
  // a level counts once the last two stages agree, so a runt pulse is lost
  assign ext_edge = ext_s[1] & ext_s[2] & ~ext_lvl;
  assign sw_sample_enable_wr = wr && PADDR_I == sarc_pkg::OFF_CTRL1;
  assign conv_end = st == sarc_pkg::ST_CONVERT && tad_tick && !halted
                    && c1[sarc_pkg::C1_ON]
                    && conv_cnt == sarc_pkg::CONV_TAD - 4'h1;
  assign seq_last = seq_cnt == c2[sarc_pkg::C2_SEQUENCES_PER_INTERRUPT +: 4];
  // reserved codes never fire, so sampling simply continues
  always_comb
  begin
    case (trig)
      sarc_pkg::TRIG_EXT:  trig_evt = ext_edge;
      sarc_pkg::TRIG_T3:   trig_evt = T3_EVT_I;
      sarc_pkg::TRIG_T5:   trig_evt = T5_EVT_I;
      sarc_pkg::TRIG_CHARGE_TIME_UNIT: trig_evt = CHARGE_TIME_UNIT_EVT_I;
      sarc_pkg::TRIG_AUTO: trig_evt = tad_tick &&
        sample_enable_cnt >= c3[sarc_pkg::C3_AUTO_SAMPLE_TIME +: 5];
      default:             trig_evt = 1'b0;
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_sample_enable = sample_enable;
    next_done = done;
    next_buffer_fill_status = buffer_fill_status;
    next_alt_b = alt_b;
    next_irq = 1'b0;
    next_div_cnt = div_cnt;
    next_sample_enable_cnt = sample_enable_cnt;
    next_conv_cnt = conv_cnt;
    next_seq_cnt = seq_cnt;
    next_wptr = wptr;
    next_scan_ptr = scan_ptr;
    next_wen = 1'b0;
    next_waddr = waddr;
    next_wdata = wdata;
    next_ext_lvl = (ext_s[1] == ext_s[2]) ? ext_s[2] : ext_lvl;
    if (sw_sample_enable_wr)
      next_sample_enable = PWDATA_I[sarc_pkg::C1_SAMPLE_ENABLE];
    if (!c1[sarc_pkg::C1_ON])
    begin
      next_st = sarc_pkg::ST_OFF;
      next_div_cnt = 8'h00;
      next_seq_cnt = 4'h0;
      next_wptr = 4'h0;
      next_alt_b = 1'b0;
      next_scan_ptr = scan_next(4'hF, scan_channel_select);
    end
    else if (!halted)
    begin
      next_div_cnt = tad_tick ? 8'h00 : div_cnt + 8'h01;
      case (st)
        sarc_pkg::ST_OFF:
          next_st = sarc_pkg::ST_HOLD;
        sarc_pkg::ST_HOLD:
          if (sample_enable)
          begin
            next_st = sarc_pkg::ST_SAMPLE;
            next_done = 1'b0;
            next_sample_enable_cnt = 5'h00;
          end
        sarc_pkg::ST_SAMPLE:
        begin
          if (tad_tick && sample_enable_cnt != 5'h1F)
            next_sample_enable_cnt = sample_enable_cnt + 5'h01;
          if (trig == sarc_pkg::TRIG_MANUAL ? !sample_enable : trig_evt)
          begin
            next_st = sarc_pkg::ST_CONVERT;
            next_sample_enable = 1'b0;
            next_conv_cnt = 4'h0;
            // restart the divider so a conversion spans whole periods
            next_div_cnt = 8'h00;
          end
          else if (!sample_enable)
            next_st = sarc_pkg::ST_HOLD;
        end
        sarc_pkg::ST_CONVERT:
        begin
          if (tad_tick)
            next_conv_cnt = conv_cnt + 4'h1;
          if (conv_end)
          begin
            next_done = 1'b1;
            next_wen = 1'b1;
            next_wdata = fmt(ADC_DATA_I, c1[sarc_pkg::C1_OUTPUT_FORMAT +: 2]);
            next_waddr = c2[sarc_pkg::C2_BUFFER_SPLIT_MODE] ? {buffer_fill_status, wptr[2:0]} : wptr;
            next_alt_b = ~alt_b & c2[sarc_pkg::C2_ALTERNATE_INPUT_SELECT];
            next_scan_ptr = scan_next(scan_ptr, scan_channel_select);
            next_seq_cnt = seq_cnt + 4'h1;
            next_wptr = wptr + 4'h1;
            if (seq_last)
            begin
              next_irq = 1'b1;
              next_seq_cnt = 4'h0;
              next_wptr = 4'h0;
              next_alt_b = 1'b0;
              next_scan_ptr = scan_next(4'hF, scan_channel_select);
              next_buffer_fill_status = c2[sarc_pkg::C2_BUFFER_SPLIT_MODE] & ~buffer_fill_status;
            end
            // hardware set beats a software clear in the same cycle
            if (c1[sarc_pkg::C1_AUTO_SAMPLE])
            begin
              next_sample_enable = 1'b1;
              next_st = sarc_pkg::ST_SAMPLE;
              next_sample_enable_cnt = 5'h00;
            end
            else
              next_st = sarc_pkg::ST_HOLD;
          end
        end
        default:
          next_st = sarc_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      st <= sarc_pkg::ST_OFF;
      sample_enable <= 1'b0;
      done <= 1'b0;
      buffer_fill_status <= 1'b0;
      alt_b <= 1'b0;
      irq <= 1'b0;
      div_cnt <= 8'h00;
      sample_enable_cnt <= 5'h00;
      conv_cnt <= 4'h0;
      seq_cnt <= 4'h0;
      wptr <= 4'h0;
      scan_ptr <= 4'h0;
      wen <= 1'b0;
      waddr <= 4'h0;
      wdata <= 16'h0000;
      ext_s <= 3'h0;
      ext_lvl <= 1'b0;
    end
    else
    begin
      st <= next_st;
      sample_enable <= next_sample_enable;
      done <= next_done;
      buffer_fill_status <= next_buffer_fill_status;
      alt_b <= next_alt_b;
      irq <= next_irq;
      div_cnt <= next_div_cnt;
      sample_enable_cnt <= next_sample_enable_cnt;
      conv_cnt <= next_conv_cnt;
      seq_cnt <= next_seq_cnt;
      wptr <= next_wptr;
      scan_ptr <= next_scan_ptr;
      wen <= next_wen;
      waddr <= next_waddr;
      wdata <= next_wdata;
      ext_s <= {ext_s[1:0], EXT_PIN_I};
      ext_lvl <= next_ext_lvl;
    end
  end

  assign bw.wr_en = wen;
  assign bw.wr_addr = waddr;
  assign bw.wr_data = wdata;

  // ---------------- analog side ----------------
  always_comb
  begin
    if (c2[sarc_pkg::C2_SCAN])
      pos_sel = {1'b0, scan_ptr};
    else if (alt_b)
      pos_sel = chsel[sarc_pkg::CH_B_POS +: 5];
    else
      pos_sel = chsel[sarc_pkg::CH_A_POS +: 5];
  end
  assign CH_POS_O = pos_sel;
  assign CH_NEG_O = alt_b ? chsel[sarc_pkg::CH_B_NEG]
                          : chsel[sarc_pkg::CH_A_NEG];
  // codes 1xx fall back to the supply rails
  assign REF_POS_EXT_O = ~c2[sarc_pkg::C2_REFERENCE_CONFIG + 2] &
                         c2[sarc_pkg::C2_REFERENCE_CONFIG];
  assign REF_NEG_EXT_O = ~c2[sarc_pkg::C2_REFERENCE_CONFIG + 2] &
                         c2[sarc_pkg::C2_REFERENCE_CONFIG + 1];
  assign SAMPLE_O = st == sarc_pkg::ST_SAMPLE;
  assign CONVERT_O = st == sarc_pkg::ST_CONVERT;
  assign ANALOG_EN_O = ~{pcfgh, pcfgl};
  assign RC_CLK_SEL_O = c3[sarc_pkg::C3_RC];
  assign CONV_IRQ_O = irq;

  // ---------------- checks ----------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  a_off_state: assert property (!c1[sarc_pkg::C1_ON] |=> st == sarc_pkg::ST_OFF)
    else $error("converter not off while disabled");
  a_idle_freeze: assert property (halted && c1[sarc_pkg::C1_ON] |=> $stable(conv_cnt) && !irq)
    else $error("sequencer moved while halted in idle");
  a_fmt_int: assert property (conv_end && c1[9:8] == sarc_pkg::FMT_INT |=> wen && wdata == {6'h00, $past(ADC_DATA_I)})
    else $error("integer format word wrong");
  a_trig_timer: assert property (st == sarc_pkg::ST_SAMPLE && trig == sarc_pkg::TRIG_T3 && T3_EVT_I && !halted && c1[sarc_pkg::C1_ON] |=> st == sarc_pkg::ST_CONVERT && !sample_enable)
    else $error("timer trigger did not start conversion");
  a_sample_enable_start: assert property (st == sarc_pkg::ST_HOLD && sample_enable && !halted && c1[sarc_pkg::C1_ON] |=> SAMPLE_O && !done)
    else $error("sampling did not begin");
  a_irq_rate: assert property (conv_end && seq_last && c1[sarc_pkg::C1_ON] |=> CONV_IRQ_O ##1 !CONV_IRQ_O)
    else $error("interrupt not raised at sequence count");
  a_tick_period: assert property (tad_tick && c3[7:0] == 8'h01 && st == sarc_pkg::ST_CONVERT && !halted |=> !tad_tick ##1 tad_tick)
    else $error("conversion clock period wrong");
  a_scan_sel: assert property (c2[sarc_pkg::C2_SCAN] && conv_end && scan_channel_select != 16'h0000 && $stable(scan_channel_select) |=> scan_channel_select[scan_ptr])
    else $error("scan picked an unselected channel");
  a_done_set: assert property (conv_end |=> done)
    else $error("done not set after conversion");
  a_auto_restart: assert property (conv_end && c1[sarc_pkg::C1_AUTO_SAMPLE] |=> sample_enable && st == sarc_pkg::ST_SAMPLE)
    else $error("auto sample did not restart");
  a_split_half: assert property (wen && c2[sarc_pkg::C2_BUFFER_SPLIT_MODE] && $stable(c2) |-> waddr[3] == $past(buffer_fill_status))
    else $error("split mode wrote the wrong half");

  c_conv_done: cover property (conv_end ##1 done);
  c_irq: cover property (CONV_IRQ_O);
  c_split_swap: cover property (c2[sarc_pkg::C2_BUFFER_SPLIT_MODE] && buffer_fill_status ##[1:200] !buffer_fill_status);
endmodule

// >>> rtl/sarc_pkg.sv
package sarc_pkg;
  // register byte offsets on the APB
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_CTRL3 = 8'h08;
  localparam logic [7:0] OFF_CHSEL = 8'h0C;
  localparam logic [7:0] OFF_PCFGL = 8'h10;
  localparam logic [7:0] OFF_PCFGH = 8'h14;
  localparam logic [7:0] OFF_SCAN  = 8'h18;
  localparam logic [1:0] BUF_WIN   = 2'h1;
  // reset value of every control register
  localparam logic [15:0] RST_REG = 16'h0000;
  // converter_control_one fields
  localparam int C1_ON   = 15;
  localparam int C1_SIDL = 13;
  localparam int C1_OUTPUT_FORMAT = 8;
  localparam int C1_TRIG = 5;
  localparam int C1_AUTO_SAMPLE = 2;
  localparam int C1_SAMPLE_ENABLE = 1;
  localparam int C1_DONE = 0;
  localparam logic [15:0] C1_WMASK = 16'hA3E4;
  // converter_control_two fields
  localparam int C2_REFERENCE_CONFIG = 13;
  localparam int C2_SCAN = 10;
  localparam int C2_BUFFER_FILL_STATUS = 7;
  localparam int C2_SEQUENCES_PER_INTERRUPT = 2;
  localparam int C2_BUFFER_SPLIT_MODE = 1;
  localparam int C2_ALTERNATE_INPUT_SELECT = 0;
  localparam logic [15:0] C2_WMASK = 16'hE43F;
  // converter_control_three fields
  localparam int C3_RC   = 15;
  localparam int C3_AUTO_SAMPLE_TIME = 8;
  localparam int C3_DIV  = 0;
  localparam logic [15:0] C3_WMASK = 16'h9FFF;
  // input select fields: mux A low byte, mux B high byte
  localparam int CH_A_POS = 0;
  localparam int CH_A_NEG = 7;
  localparam int CH_B_POS = 8;
  localparam int CH_B_NEG = 15;
  localparam logic [15:0] CH_WMASK = 16'h9F9F;
  localparam logic [15:0] PH_WMASK = 16'h0003;
  // trigger source codes
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_EXT    = 3'h1;
  localparam logic [2:0] TRIG_T3     = 3'h2;
  localparam logic [2:0] TRIG_T5     = 3'h4;
  localparam logic [2:0] TRIG_CHARGE_TIME_UNIT   = 3'h6;
  localparam logic [2:0] TRIG_AUTO   = 3'h7;
  // output format codes
  localparam logic [1:0] FMT_INT   = 2'h0;
  localparam logic [1:0] FMT_SINT  = 2'h1;
  localparam logic [1:0] FMT_FRAC  = 2'h2;
  localparam logic [1:0] FMT_SFRAC = 2'h3;
  // conversion length in conversion clock periods
  localparam logic [3:0] CONV_TAD = 4'hC;
  typedef enum logic [1:0] {ST_OFF, ST_HOLD, ST_SAMPLE, ST_CONVERT}
    sarc_state_type;
endpackage

// >>> rtl/sarc_buf_if.sv
`timescale 1ns/1ps
interface sarc_buf_if #(
  parameter int W  = 16,
  parameter int AW = 4
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0]  wr_data;
  logic [AW-1:0] rd_addr;
  logic [W-1:0]  rd_data;
  modport writer (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
  modport mem    (input wr_en, input wr_addr, input wr_data,
                  input rd_addr, output rd_data);
endinterface

// >>> rtl/sarc_result_mem.sv
`timescale 1ns/1ps
module sarc_result_mem #(
  parameter int W     = 16,
  parameter int AW    = 4,
  parameter int DEPTH = 16
)(
  // clock and reset
  input wire logic  clk_i,
  input wire logic  rst_i,
  // port pair
  sarc_buf_if.mem   bus
);
  logic [W-1:0] store [DEPTH];
  logic [W-1:0] next_rd_data;

  if (DEPTH != 2 ** AW) begin : g_chk
    $error("sarc_result_mem: DEPTH must equal 2**AW");
  end

  always_comb
  begin
    next_rd_data = store[bus.rd_addr];
  end

  // array has no reset: software only reads words the converter wrote
  always_ff @(posedge clk_i)
  begin
    if (bus.wr_en)
    begin
      store[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus.rd_data <= '0;
    end
    else
    begin
      bus.rd_data <= next_rd_data;
    end
  end
endmodule

// >>> tb/sarc_analog_model.sv
`timescale 1ns/1ps
module sarc_analog_model (
  // clock
  input  wire logic       clk_i,
  // converter side
  input  wire logic [4:0] ch_pos_i,
  input  wire logic       convert_i,
  output logic      [9:0] adc_data_o
);
  logic [9:0] next_adc_data;
  // code carries the channel number so a wrong mux pick shows up
  always_comb
  begin
    next_adc_data = adc_data_o;
    if (!convert_i)
      next_adc_data = {ch_pos_i, 5'h0A};
  end
  // frozen through a conversion, since the core result is taken at its end
  always_ff @(posedge clk_i)
  begin
    adc_data_o <= next_adc_data;
  end
endmodule

// >>> tb/test_sar_adc_control_sequencer.sv
`timescale 1ns/1ps
module test_sar_adc_control_sequencer;
  logic        mclk, rst, psel, penable, pwrite, idle, ext_pin, t3, t5, charge_time_unit;
  logic        pready, pslverr, sample, convert, ch_neg, rpos, rneg, e, ok;
  logic        rc_sel, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0]  ch_pos;
  logic [9:0]  adc;
  logic [17:0] an_en;
  int          err_total = 0, tests_run = 0, cycles = 0, irq_cnt = 0;
  int          conv_starts = 0, run = 0, conv_len = 0, base, i, j;
  int          trg[5] = '{1, 2, 4, 6, 5};
  logic [15:0] fmt[4] = '{16'h00AA, 16'hFEAA, 16'h2A80, 16'hAA80};
  logic [7:0]  offs[4] = '{sarc_pkg::OFF_CTRL2, sarc_pkg::OFF_CTRL3,
                           sarc_pkg::OFF_CHSEL, sarc_pkg::OFF_PCFGH};
  logic [15:0] msk[4] = '{sarc_pkg::C2_WMASK, sarc_pkg::C3_WMASK,
                          sarc_pkg::CH_WMASK, sarc_pkg::PH_WMASK};

  sarc_top #(.BUF_DEPTH(16)) dut_u (
    .MCLK_I(mclk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .IDLE_I(idle), .EXT_PIN_I(ext_pin), .T3_EVT_I(t3), .T5_EVT_I(t5),
    .CHARGE_TIME_UNIT_EVT_I(charge_time_unit), .ADC_DATA_I(adc), .SAMPLE_O(sample),
    .CONVERT_O(convert), .CH_POS_O(ch_pos), .CH_NEG_O(ch_neg),
    .REF_POS_EXT_O(rpos), .REF_NEG_EXT_O(rneg), .ANALOG_EN_O(an_en),
    .RC_CLK_SEL_O(rc_sel), .CONV_IRQ_O(irq)
  );
  sarc_analog_model front_u (
    .clk_i(mclk), .ch_pos_i(ch_pos), .convert_i(convert), .adc_data_o(adc)
  );

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task end_sim;
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // event counters; the ceiling is far above the under a thousand cycles needed
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (irq === 1'b1)
      irq_cnt <= irq_cnt + 1;
    if (convert === 1'b1 && run == 0)
      conv_starts <= conv_starts + 1;
    if (convert === 1'b1)
      run <= run + 1;
    else
    begin
      if (run != 0)
        conv_len <= run;
      run <= 0;
    end
    if (cycles == 20000)
    begin
      err_total = err_total + 1;
      end_sim;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] want, input string n);
    tests_run = tests_run + 1;
    if (seen !== want)
    begin
      err_total = err_total + 1;
      $display("[FAIL] %s expected %h seen %h", n, want, seen);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // only the bench timeout ends a wait for ready
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a);
    apb(1'b0, a, 16'h0000);
  endtask

  task wait_done;
    ok = 1'b0;
    repeat (40)
      if (!ok)
      begin
        rd(sarc_pkg::OFF_CTRL1);
        ok = (q[sarc_pkg::C1_DONE] === 1'b1);
      end
  endtask

  // external pin is held a few cycles so its synchroniser sees the edge
  task fire(input int c);
    @(posedge mclk);
    ext_pin <= (c == 1 || c == 5);
    t3 <= (c == 2 || c == 5);
    t5 <= (c == 4 || c == 5);
    charge_time_unit <= (c == 6 || c == 5);
    @(posedge mclk);
    {t3, t5, charge_time_unit} <= 3'h0;
    repeat (4) @(posedge mclk);
    ext_pin <= 1'b0;
  endtask

  initial
  begin
    {psel, penable, pwrite, idle, ext_pin, t3, t5, charge_time_unit} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk(an_en, 18'h3FFFF, "analog_en_reset");
    for (i = 0; i < 8; i++)
    begin
      rd(8'(i * 4));
      chk(q, 32'h0, "reset_value");
      chk(e, i == 7, "unmapped_error");
    end
    for (i = 0; i < 4; i++)
    begin
      wr(offs[i], 16'hFFFF);
      rd(offs[i]);
      chk(q, {16'h0000, msk[i]}, "write_mask");
    end
    chk(an_en, 18'h0FFFF, "analog_en_high");
    chk(rc_sel, 1'b1, "rc_clock_select");
    chk(ch_neg, 1'b1, "neg_input");
    wr(sarc_pkg::OFF_PCFGL, 16'h00F0);
    wr(sarc_pkg::OFF_PCFGH, 16'h0000);
    // the last write lands at the edge the task returns on
    @(posedge mclk);
    chk(an_en, 18'h3FF0F, "analog_en_low");
    for (i = 0; i < 8; i++)
    begin
      wr(sarc_pkg::OFF_CTRL2, 16'(i << 13));
      @(posedge mclk);
      chk({rpos, rneg}, {i == 1 || i == 3, i == 2 || i == 3}, "ref");
    end
    wr(sarc_pkg::OFF_CTRL2, 16'h0000);
    wr(sarc_pkg::OFF_CTRL3, 16'h0001);
    wr(sarc_pkg::OFF_CHSEL, 16'h0005);
    // manual trigger: clearing sample_enable starts the conversion
    for (i = 0; i < 4; i++)
    begin
      base = irq_cnt;
      wr(sarc_pkg::OFF_CTRL1, 16'h8000 | 16'(i << 8));
      wr(sarc_pkg::OFF_CTRL1, 16'h8002 | 16'(i << 8));
      // one edge takes the write, the next moves the state
      repeat (2) @(posedge mclk);
      chk(sample, 1'b1, "sampling");
      wr(sarc_pkg::OFF_CTRL1, 16'h8000 | 16'(i << 8));
      wait_done;
      // let the edge counters see the end of the conversion
      @(posedge mclk);
      chk(ok, 1'b1, "done");
      chk(conv_len, 24, "conv_length");
      chk(irq_cnt - base, 1, "irq_each");
      rd(8'h40);
      chk(q, {16'h0000, fmt[i]}, "result_format");
    end
    // stop_in_idle with idle high must freeze a running conversion
    wr(sarc_pkg::OFF_CTRL1, 16'hA002);
    wr(sarc_pkg::OFF_CTRL1, 16'hA000);
    @(posedge mclk);
    idle <= 1'b1;
    repeat (40) @(posedge mclk);
    chk(convert, 1'b1, "idle_freeze");
    idle <= 1'b0;
    wait_done;
    chk(ok, 1'b1, "idle_resume");
    wr(sarc_pkg::OFF_CTRL3, 16'h0000);
    for (i = 0; i < 5; i++)
    begin
      wr(sarc_pkg::OFF_CTRL1, 16'h8000 | 16'(trg[i] << 5));
      wr(sarc_pkg::OFF_CTRL1, 16'h8002 | 16'(trg[i] << 5));
      fire(trg[i]);
      wait_done;
      chk(ok, trg[i] != 5, "trigger_source");
    end
    // auto trigger, auto restart, scan of channels 1 and 3, four per irq
    wr(sarc_pkg::OFF_CTRL1, 16'h0000);
    wr(sarc_pkg::OFF_CTRL3, 16'h0100);
    wr(sarc_pkg::OFF_CTRL2, 16'h040E);
    wr(sarc_pkg::OFF_SCAN, 16'h000A);
    base = conv_starts;
    j = irq_cnt;
    wr(sarc_pkg::OFF_CTRL1, 16'h80E4);
    wr(sarc_pkg::OFF_CTRL1, 16'h80E6);
    for (i = 0; i < 800 && irq_cnt == j; i++)
      @(posedge mclk);
    chk(conv_starts - base, 4, "seq_per_irq");
    wr(sarc_pkg::OFF_CTRL1, 16'h0000);
    // split mode: the interrupt flips filling to the upper half
    rd(sarc_pkg::OFF_CTRL2);
    chk(q, 32'h0000048E, "fill_status");
    for (i = 0; i < 4; i++)
    begin
      rd(8'h40 + 8'(i * 4));
      chk(q, {22'h0, i[0] ? 5'd3 : 5'd1, 5'h0A}, "scan");
    end
    end_sim;
  end
endmodule
